//--- verilog/adc_readout_defines.svh
// Timing and layout constants shared by both ends of the converter output link.
`ifndef ADC_READOUT_DEFINES_SVH
`define ADC_READOUT_DEFINES_SVH
// Clock period in picoseconds (200 MHz).
`define CLK_PERIOD_PS 5000
// Typical and longest conversion time in nanoseconds.
`define CONV_TYP_NS 1400
`define CONV_MAX_NS 2000
// Longest acquisition time and throughput period in nanoseconds.
`define ACQ_MAX_NS 150
`define THROUGHPUT_NS 2500
// Wake-up time from nap in nanoseconds.
`define NAP_WAKE_NS 200
// Reference settling after sleep in milliseconds.
`define SLEEP_WAKE_MS 10
// Field layout of the output word.
`define TAG_WIDTH 4
`define STATUS_WIDTH 7
`define STATUS_PINS 3
// Host side cycle counts: sync margin, start hold and read timeout.
`define SYNC_MARGIN_CYC 8
`define START_HOLD_CYC 16
`define READ_TIMEOUT_CYC 16
`endif

//--- verilog/adc_readout_pkg.sv
// Types shared by both ends of the converter output link.
package adc_readout_pkg;
    typedef enum logic [2:0] {
        ST_ACTIVE = 3'h0,
        ST_ACQUIRE = 3'h1,
        ST_CONVERT = 3'h3,
        ST_WAKE = 3'h2,
        ST_NAP = 3'h6,
        ST_SLEEP = 3'h7
    } conv_state_t;
    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_START = 3'h1,
        H_WAIT = 3'h3,
        H_READ = 3'h2,
        H_DONE = 3'h6,
        H_SETTLE = 3'h7
    } host_state_t;
endpackage

//--- verilog/adc_link_if.sv
// Parallel output bus joining the converter and its reading host.
`timescale 1ns/1ps
interface adc_link_if #(parameter int DATA_WIDTH = 12);
    logic [DATA_WIDTH+3:0] data_o;
    logic [DATA_WIDTH+3:0] data_oe_n;
    logic read_n;
    logic chip_select_n;
    logic conversion_start_n;
    logic power_down_n;
    logic polarity_select;
    logic busy_n;
    modport device (
        output data_o, data_oe_n, busy_n,
        input read_n, chip_select_n, conversion_start_n, power_down_n, polarity_select
    );
    modport host (
        input data_o, data_oe_n, busy_n,
        output read_n, chip_select_n, conversion_start_n, power_down_n, polarity_select
    );
endinterface

//--- verilog/adc_output_device.sv
// Converter end: conversion timing, output word, readback and shutdown.
`timescale 1ns/1ps
`include "adc_readout_defines.svh"

module adc_output_device
    import adc_readout_pkg::*;
#(
    parameter int DATA_WIDTH = 12,
    parameter int CONV_NS = `CONV_TYP_NS
)
(
    input wire logic clk_in,
    input wire logic reset_in,
    adc_link_if.device link,
    input wire logic [DATA_WIDTH-1:0] sample_in,
    input wire logic [2:0] mux_addr_in,
    input wire logic diff_in,
    input wire logic readback_in,
    input wire logic [`STATUS_WIDTH-1:0] sequencer_status_word_in,
    output logic nap_out,
    output logic sleep_out
);
    // Cycle counts derived from the printed times; the conversion time rounds up, the others round down.
    localparam int CONV_CYC = (CONV_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
    localparam int CONV_MAX_CYC = (`CONV_MAX_NS * 1000) / `CLK_PERIOD_PS;
    localparam int CONV_USE = (CONV_CYC > CONV_MAX_CYC) ? CONV_MAX_CYC : CONV_CYC;
    localparam int ACQ_CYC = (`ACQ_MAX_NS * 1000) / `CLK_PERIOD_PS;
    localparam int THRU_CYC = (`THROUGHPUT_NS * 1000) / `CLK_PERIOD_PS;
    localparam int ACQ_USE = (ACQ_CYC + CONV_USE > THRU_CYC) ? THRU_CYC - CONV_USE : ACQ_CYC;
    localparam int NAP_CYC = (`NAP_WAKE_NS * 1000) / `CLK_PERIOD_PS;
    localparam int W = DATA_WIDTH + `TAG_WIDTH;
    localparam int CW = 12;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    // All link inputs come from another party, so they pass three flops and a filter register that updates once the last two agree.
    logic [4:0] sync1, sync2, sync3, pins;
    logic [4:0] next_pins;
    always_comb
    begin
        next_pins = pins;
        for (int i = 0; i < 5; i++)
        begin
            if (sync2[i] == sync3[i])
            begin
                next_pins[i] = sync3[i];
            end
        end
    end
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            sync1 <= 5'h1f;
            sync2 <= 5'h1f;
            sync3 <= 5'h1f;
            pins <= 5'h1f;
        end
        else
        begin
            sync1 <= {link.read_n, link.chip_select_n, link.conversion_start_n,
                      link.power_down_n, link.polarity_select};
            sync2 <= sync1;
            sync3 <= sync2;
            pins <= next_pins;
        end
    end
    logic rd_n, cs_n, start_n, pd_n, bipolar;
    assign {rd_n, cs_n, start_n, pd_n, bipolar} = pins;

    // ************************************************************
    // Conversion and shutdown sequencer
    // ************************************************************
    conv_state_t state, next_state;
    logic [CW-1:0] count, next_count;
    logic [W-1:0] word, next_word;
    logic busy_n, next_busy_n;
    logic nap, next_nap, sleep, next_sleep;
    logic [DATA_WIDTH-1:0] code;

    // Bipolar codes flip the top bit of the offset sample into two's complement.
    always_comb
    begin
        code = sample_in;
        if (bipolar)
        begin
            code[DATA_WIDTH-1] = ~sample_in[DATA_WIDTH-1];
        end
    end

    always_comb
    begin
        next_state = state;
        next_count = count;
        next_word = word;
        next_busy_n = busy_n;
        next_nap = nap;
        next_sleep = sleep;
        case (state)
            ST_ACTIVE:
            begin
                next_busy_n = ~readback_in;
                if (!pd_n && busy_n)
                begin
                    // Shutdown type is sampled once on entry; a later select change is ignored.
                    next_state = cs_n ? ST_SLEEP : ST_NAP;
                    next_nap = ~cs_n;
                    next_sleep = cs_n;
                end
                else if (!start_n && !cs_n && !readback_in)
                begin
                    next_state = ST_ACQUIRE;
                    next_busy_n = 1'b0;
                    next_count = CW'(ACQ_USE - 1);
                end
            end
            ST_ACQUIRE:
            begin
                if (count == '0)
                begin
                    next_state = ST_CONVERT;
                    next_count = CW'(CONV_USE - 1);
                end
                else
                begin
                    next_count = count - 1'b1;
                end
            end
            ST_CONVERT:
            begin
                // Start is ignored here, so a held start cannot restart the conversion.
                if (count == '0)
                begin
                    next_word = {diff_in, mux_addr_in, code};
                    next_busy_n = 1'b1;
                    next_state = ST_ACTIVE;
                end
                else
                begin
                    next_count = count - 1'b1;
                end
            end
            ST_NAP, ST_SLEEP:
            begin
                if (pd_n)
                begin
                    next_state = ST_WAKE;
                    next_count = CW'(NAP_CYC - 1);
                end
            end
            ST_WAKE:
            begin
                if (count == '0)
                begin
                    next_state = ST_ACTIVE;
                    next_nap = 1'b0;
                    next_sleep = 1'b0;
                end
                else
                begin
                    next_count = count - 1'b1;
                end
            end
            default:
            begin
                next_state = ST_ACTIVE;
            end
        endcase
    end

    // ************************************************************
    // Output drivers
    // ************************************************************
    logic [W-1:0] dout, next_dout, oe_n, next_oe_n;
    // Readback puts the status word on the top pins and floats the rest.
    always_comb
    begin
        next_dout = word;
        next_oe_n = '1;
        if (readback_in)
        begin
            next_dout = '0;
            next_dout[DATA_WIDTH-1 -: `STATUS_PINS] =
                sequencer_status_word_in[`STATUS_PINS-1:0];
            if (!rd_n && !cs_n)
            begin
                next_oe_n[DATA_WIDTH-1 -: `STATUS_PINS] = '0;
                next_oe_n[W-1 -: `TAG_WIDTH] = '0;
                next_dout[W-1 -: `TAG_WIDTH] =
                    sequencer_status_word_in[`STATUS_WIDTH-1:`STATUS_PINS];
            end
            // Lower result pins keep oe_n high regardless of read.
        end
        else if (!rd_n && !cs_n)
        begin
            next_oe_n = '0;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state <= ST_ACTIVE;
            count <= '0;
            word <= '0;
            busy_n <= 1'b1;
            nap <= 1'b0;
            sleep <= 1'b0;
            dout <= '0;
            oe_n <= '1;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            word <= next_word;
            busy_n <= next_busy_n;
            nap <= next_nap;
            sleep <= next_sleep;
            dout <= next_dout;
            oe_n <= next_oe_n;
        end
    end

    assign link.data_o = dout;
    assign link.data_oe_n = oe_n;
    assign link.busy_n = busy_n;
    assign nap_out = nap;
    assign sleep_out = sleep;
endmodule

//--- verilog/adc_output_host.sv
// Host end: starts conversions, waits on busy, reads the word, controls shutdown.
`timescale 1ns/1ps
`include "adc_readout_defines.svh"
module adc_output_host
    import adc_readout_pkg::*;
#(
    parameter int DATA_WIDTH = 12,
    parameter int SETTLE_CYCLES = (`SLEEP_WAKE_MS * 1000000) / (`CLK_PERIOD_PS / 1000)
)
(
    input wire logic clk_in,
    input wire logic reset_in,
    adc_link_if.host link,
    input wire logic start_in,
    input wire logic bipolar_in,
    input wire logic shutdown_in,
    input wire logic sleep_select_in,
    output logic [DATA_WIDTH+3:0] word_out,
    output logic word_valid_out,
    output logic ready_out
);
    localparam int W = DATA_WIDTH + `TAG_WIDTH;
    localparam int READ_CYC = `READ_TIMEOUT_CYC;
    // Nap wake timer of the device plus the delay of its input synchronisers.
    localparam int NAP_SETTLE = (`NAP_WAKE_NS * 1000) / `CLK_PERIOD_PS + `SYNC_MARGIN_CYC;

    // ************************************************************
    // Busy synchroniser
    // ************************************************************
    logic b1, b2, b3, busy_n, next_busy_n;
    assign next_busy_n = (b2 == b3) ? b3 : busy_n;
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            b1 <= 1'b1;
            b2 <= 1'b1;
            b3 <= 1'b1;
            busy_n <= 1'b1;
        end
        else
        begin
            b1 <= link.busy_n;
            b2 <= b1;
            b3 <= b2;
            busy_n <= next_busy_n;
        end
    end

    // ************************************************************
    // Host sequencer
    // ************************************************************
    host_state_t state, next_state;
    logic [31:0] count, next_count;
    logic rd_n, next_rd_n, cs_n, next_cs_n, st_n, next_st_n, pd_n, next_pd_n;
    logic pol, next_pol, valid, next_valid;
    logic [W-1:0] word, next_word;
    logic was_sleep, next_was_sleep;
    logic ready, next_ready;

    // Ready is registered so the output comes straight from a flop.
    assign next_ready = (next_state == H_IDLE) && next_pd_n;

    // Reads stay off the bus while busy is low, acting as the wait state.
    always_comb
    begin
        next_state = state;
        next_count = count;
        next_rd_n = 1'b1;
        next_cs_n = cs_n;
        next_st_n = 1'b1;
        next_pd_n = pd_n;
        next_pol = pol;
        next_valid = 1'b0;
        next_word = word;
        next_was_sleep = was_sleep;
        case (state)
            H_IDLE:
            begin
                if (shutdown_in)
                begin
                    next_cs_n = sleep_select_in;
                    next_pd_n = 1'b0;
                    next_was_sleep = sleep_select_in;
                end
                else if (!pd_n)
                begin
                    next_pd_n = 1'b1;
                    next_cs_n = 1'b0;
                    // A start sent before the device has woken would simply be refused.
                    next_state = H_SETTLE;
                    next_count = was_sleep ? 32'(SETTLE_CYCLES) : 32'(NAP_SETTLE);
                end
                else if (start_in)
                begin
                    next_cs_n = 1'b0;
                    next_st_n = 1'b0;
                    next_pol = bipolar_in;
                    next_state = H_START;
                    next_count = 32'(`START_HOLD_CYC);
                end
            end
            H_START:
            begin
                next_st_n = 1'b0;
                if (!busy_n || count == 32'h0)
                begin
                    next_state = H_WAIT;
                end
                else
                begin
                    next_count = count - 32'h1;
                end
            end
            H_WAIT:
            begin
                if (busy_n)
                begin
                    next_state = H_READ;
                    next_rd_n = 1'b0;
                    next_count = READ_CYC;
                end
            end
            H_READ:
            begin
                next_rd_n = 1'b0;
                // The word is taken only once every pin is driven, never from a floating bus.
                if (!(|link.data_oe_n))
                begin
                    next_word = link.data_o;
                    next_valid = 1'b1;
                    next_rd_n = 1'b1;
                    next_state = H_DONE;
                end
                else if (count == 32'h0)
                begin
                    next_rd_n = 1'b1;
                    next_state = H_DONE;
                end
                else
                begin
                    next_count = count - 32'h1;
                end
            end
            H_DONE:
            begin
                // One conversion per reset: the host parks here until the next reset.
                next_state = H_DONE;
            end
            H_SETTLE:
            begin
                if (count == 32'h0)
                begin
                    next_state = H_IDLE;
                    next_was_sleep = 1'b0;
                end
                else
                begin
                    next_count = count - 32'h1;
                end
            end
            default:
            begin
                next_state = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state <= H_IDLE;
            count <= 32'h0;
            rd_n <= 1'b1;
            cs_n <= 1'b1;
            st_n <= 1'b1;
            pd_n <= 1'b1;
            pol <= 1'b0;
            valid <= 1'b0;
            word <= '0;
            was_sleep <= 1'b0;
            ready <= 1'b0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            rd_n <= next_rd_n;
            cs_n <= next_cs_n;
            st_n <= next_st_n;
            pd_n <= next_pd_n;
            pol <= next_pol;
            valid <= next_valid;
            word <= next_word;
            was_sleep <= next_was_sleep;
            ready <= next_ready;
        end
    end

    assign link.read_n = rd_n;
    assign link.chip_select_n = cs_n;
    assign link.conversion_start_n = st_n;
    assign link.power_down_n = pd_n;
    assign link.polarity_select = pol;
    assign word_out = word;
    assign word_valid_out = valid;
    assign ready_out = ready;
endmodule

//--- dv/adc_output_asserts.sv
// Concurrent checks on the parallel link between converter and host.
`timescale 1ns/1ps
module adc_output_asserts
#(
    parameter int DATA_WIDTH = 12
)
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [DATA_WIDTH+3:0] data_o,
    input wire logic [DATA_WIDTH+3:0] data_oe_n,
    input wire logic read_n,
    input wire logic chip_select_n,
    input wire logic conversion_start_n,
    input wire logic power_down_n,
    input wire logic polarity_select,
    input wire logic busy_n
);
    // Typical conversion is 280 cycles; acquire 30 plus longest convert 400.
    localparam int BUSY_MIN = 280;
    localparam int BUSY_MAX = 430;
    logic [9:0] busy_cnt;
    logic conv_flag;
    logic [3:0] idle_cnt;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    // ****************************************
    // Helper counters
    // ****************************************
    // A busy fall seen with start low marks a conversion, not a readback.
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            busy_cnt <= 10'h000;
            conv_flag <= 1'b0;
            idle_cnt <= 4'h0;
        end
        else
        begin
            busy_cnt <= busy_n ? 10'h000 : busy_cnt + 10'h001;
            conv_flag <= !busy_n && (conv_flag || (!conversion_start_n && busy_cnt == 10'h000));
            idle_cnt <= !(read_n || chip_select_n) ? 4'h0 :
                (idle_cnt == 4'hf ? idle_cnt : idle_cnt + 4'h1);
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    // Input sync latency means the drivers may lag read by a few cycles.
    a_drive_needs_read: assert property (idle_cnt >= 4'h8 |-> &data_oe_n)
        else $error("outputs driven without read and select");
    a_read_enables_drive: assert property ($fell(read_n) && !chip_select_n |->
        ##[1:10] !(&data_oe_n[DATA_WIDTH-1:0]))
        else $error("read did not enable the outputs");
    a_busy_on_start: assert property ($fell(conversion_start_n) && !chip_select_n &&
        power_down_n && busy_n |-> ##[1:10] !busy_n)
        else $error("start did not begin a conversion");
    a_busy_min_hold: assert property ($fell(busy_n) |-> !busy_n [*8])
        else $error("busy released too early");
    a_conv_time_bound: assert property ($rose(busy_n) && conv_flag |->
        busy_cnt >= BUSY_MIN && busy_cnt <= BUSY_MAX)
        else $error("conversion length out of range");
    a_word_holds: assert property (!(&data_oe_n) && $past(!(&data_oe_n)) |->
        $stable(data_o))
        else $error("output word changed while read");
    a_readback_floats: assert property (!busy_n && !conv_flag && busy_cnt > 10'h000 |->
        &data_oe_n[8:0])
        else $error("lower pins driven in readback");
    a_shutdown_idle: assert property (!power_down_n [*8] |-> busy_n)
        else $error("conversion running in shutdown");
endmodule

//--- dv/adc_output_readback_shutdown_tb_top.sv
// Self-checking bench joining both ends of the converter link.
`timescale 1ns/1ps
module adc_output_readback_shutdown_tb_top;
    logic clk_in, reset_in, diff_in, readback_in, start_in, bipolar_in;
    logic shutdown_in, sleep_select_in, nap_out, sleep_out, word_valid_out, ready_out;
    logic [11:0] sample_in;
    logic [2:0] mux_addr_in;
    logic [6:0] sequencer_status_word_in;
    logic [15:0] word_out;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;

    adc_link_if #(.DATA_WIDTH(12)) link();
    adc_output_device i_adc_output_device (.clk_in(clk_in), .reset_in(reset_in),
        .link(link), .sample_in(sample_in), .mux_addr_in(mux_addr_in), .diff_in(diff_in),
        .readback_in(readback_in), .sequencer_status_word_in(sequencer_status_word_in),
        .nap_out(nap_out), .sleep_out(sleep_out));
    // Settling is cut to 50 cycles so the sleep case stays short.
    adc_output_host #(.SETTLE_CYCLES(50)) i_adc_output_host (.clk_in(clk_in),
        .reset_in(reset_in), .link(link), .start_in(start_in), .bipolar_in(bipolar_in),
        .shutdown_in(shutdown_in), .sleep_select_in(sleep_select_in), .word_out(word_out),
        .word_valid_out(word_valid_out), .ready_out(ready_out));
    adc_output_asserts i_adc_output_asserts (.clk_in(clk_in), .reset_in(reset_in),
        .data_o(link.data_o), .data_oe_n(link.data_oe_n), .read_n(link.read_n),
        .chip_select_n(link.chip_select_n), .conversion_start_n(link.conversion_start_n),
        .power_down_n(link.power_down_n), .polarity_select(link.polarity_select),
        .busy_n(link.busy_n));

    // ****************************************
    // Clock, timeout and report
    // ****************************************
    initial
    begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    // The whole run needs about 2700 cycles; a hang is cut at 20000.
    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_word({15'h0000, got}, {15'h0000, exp});
    endtask

    // ****************************************
    // Shared steps
    // ****************************************
    // The host takes one conversion per reset, so every test starts here.
    task automatic do_reset(input logic rb);
        @(posedge clk_in);
        reset_in <= 1'b1;
        readback_in <= rb;
        start_in <= 1'b0;
        shutdown_in <= 1'b0;
        repeat (8) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic convert_once(output logic ok);
        ok = 1'b0;
        @(posedge clk_in);
        start_in <= 1'b1;
        for (int i = 0; i < 1500 && !ok; i++)
        begin
            @(posedge clk_in);
            #1 ok = (word_valid_out === 1'b1);
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_convert(input logic bip, input logic [11:0] s, input logic [2:0] a,
        input logic d);
        logic ok;
        do_reset(1'b0);
        sample_in <= s;
        mux_addr_in <= a;
        diff_in <= d;
        bipolar_in <= bip;
        convert_once(ok);
        check_bit(ok, 1'b1);
        check_word(word_out, {d, a, bip ? s ^ 12'h800 : s});
        check_bit(link.busy_n, 1'b1);
        $display("test convert bip=%0b done", bip);
    endtask

    task automatic t_readback();
        logic seen;
        seen = 1'b0;
        do_reset(1'b1);
        sequencer_status_word_in <= 7'h5a;
        repeat (20) @(posedge clk_in);
        start_in <= 1'b1;
        repeat (200)
        begin
            @(posedge clk_in);
            #1 seen = seen | (word_valid_out === 1'b1);
        end
        check_bit(seen, 1'b0);
        check_bit(link.busy_n, 1'b0);
        check_word({7'h00, link.data_oe_n[8:0]}, 16'h01ff);
        check_word({13'h0000, link.data_o[11:9]}, 16'h0002);
        check_word({13'h0000, link.data_oe_n[11:9]}, 16'h0007);
        readback_in <= 1'b0;
        $display("test readback done");
    endtask

    task automatic t_shutdown(input logic slp);
        logic ok;
        int n;
        ok = 1'b0;
        do_reset(1'b0);
        sample_in <= 12'h3c5;
        bipolar_in <= 1'b0;
        sleep_select_in <= slp;
        shutdown_in <= 1'b1;
        for (int i = 0; i < 100 && !ok; i++)
        begin
            @(posedge clk_in);
            #1 ok = ((nap_out | sleep_out) === 1'b1);
        end
        check_bit(link.power_down_n, 1'b0);
        check_bit(link.chip_select_n, slp);
        check_bit(sleep_out, slp);
        check_bit(nap_out, !slp);
        @(posedge clk_in);
        shutdown_in <= 1'b0;
        ok = 1'b0;
        n = 0;
        for (int i = 0; i < 300 && !ok; i++)
        begin
            @(posedge clk_in);
            #1 ok = (ready_out === 1'b1);
            n++;
        end
        check_bit(ok, 1'b1);
        check_bit(n >= (slp ? 50 : 40), 1'b1);
        convert_once(ok);
        check_bit(ok, 1'b1);
        check_word({4'h0, word_out[11:0]}, 16'h03c5);
        $display("test shutdown sleep=%0b done", slp);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        reset_in = 1'b1;
        sample_in = 12'h000;
        mux_addr_in = 3'h0;
        diff_in = 1'b0;
        readback_in = 1'b0;
        sequencer_status_word_in = 7'h00;
        start_in = 1'b0;
        bipolar_in = 1'b0;
        shutdown_in = 1'b0;
        sleep_select_in = 1'b0;
        t_convert(1'b0, 12'h000, 3'h0, 1'b0);
        t_convert(1'b0, 12'hfff, 3'h7, 1'b1);
        t_convert(1'b1, 12'h800, 3'h5, 1'b0);
        t_convert(1'b1, 12'h000, 3'h2, 1'b1);
        t_convert(1'b1, 12'h7ff, 3'h1, 1'b0);
        t_readback();
        t_shutdown(1'b0);
        t_shutdown(1'b1);
        stop_test();
    end
endmodule
